// >>> design/triple_timer_counter.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "triple_timer_consts.svh"
module triple_timer_counter
   import triple_timer_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic ext_irq_one_n,
   input wire logic periph_irq_n,
   input wire logic vector_t0,
   input wire logic vector_t1,
   input wire logic vector_ext1,
   input wire logic vector_periph,
   output logic overflow_pin_zero,
   output logic overflow_pin_one,
   output logic t0_irq,
   output logic t1_irq,
   output logic ext1_irq,
   output logic periph_irq,
   output logic t2_irq,
   output logic rx_shift_clk,
   output logic tx_shift_clk
);
   // ==========================================================
   // Register bus decode.
   reg_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction

   wire wr_timer_control_flags = hit(req, `OFS_TIMER_CONTROL_FLAGS);
   wire wr_timer_mode_register = hit(req, `OFS_TIMER_MODE_REGISTER);
   wire wr_timer2_control = hit(req, `OFS_TIMER2_CONTROL);

   logic [7:0] timer_control_flags_reg, timer_mode_register_reg, timer_rate_select_reg, timer2_control_reg, rcap_lo_reg, rcap_hi_reg;
   logic [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg, tl2_reg, th2_reg;
   logic [7:0] tl0_next, th0_next, tl1_next, th1_next, tl2_next, th2_next;

   mode_field_t mf0, mf1;
   assign mf0 = mode_field_t'(timer_mode_register_reg[3:0]);
   assign mf1 = mode_field_t'(timer_mode_register_reg[7:4]);
   timer_mode_t mode0, mode1;
   assign mode0 = timer_mode_t'({mf0.mode_bit_high, mf0.mode_bit_low});
   assign mode1 = timer_mode_t'({mf1.mode_bit_high, mf1.mode_bit_low});

   // ==========================================================
   // Pin synchronisers; the first stage feeds only the second.
   logic [3:0] sync1_reg, sync2_reg, sync3_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_reg <= 4'hF;
         sync2_reg <= 4'hF;
         sync3_reg <= 4'hF;
      end else begin
         sync1_reg <= {periph_irq_n, ext_irq_one_n, count_pin_one, count_pin_zero};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   wire [3:0] fall = sync3_reg & ~sync2_reg;
   wire pin0_fall = fall[0];
   wire pin1_fall = fall[1];
   wire ext1_fall = fall[2];
   wire periph_fall = fall[3];
   wire ext1_level = sync2_reg[2];
   wire periph_level = sync2_reg[3];

   // ==========================================================
   // Prescalers: one free-running count per rate, pulses are enables.
   logic [3:0] div12_reg, div4_reg, div2_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div12_reg <= 4'h0;
         div4_reg <= 4'h0;
         div2_reg <= 4'h0;
      end else begin
         div12_reg <= (div12_reg == `SLOW_DIV - 4'd1) ? 4'h0 : div12_reg + 4'd1;
         div4_reg <= (div4_reg == `FAST_DIV - 4'd1) ? 4'h0 : div4_reg + 4'd1;
         div2_reg <= (div2_reg == `BAUD_DIV - 4'd1) ? 4'h0 : div2_reg + 4'd1;
      end
   end
   wire tick12 = (div12_reg == 4'h0);
   wire tick4 = (div4_reg == 4'h0);
   wire tick2 = (div2_reg == 4'h0);
   wire tick_t0 = timer_rate_select_reg[`BIT_RATE_SEL_ZERO] ? tick4 : tick12;
   wire tick_t1 = timer_rate_select_reg[`BIT_RATE_SEL_ONE] ? tick4 : tick12;
   wire tick_t2 = timer_rate_select_reg[`BIT_RATE_SEL_TWO] ? tick4 : tick12;

   // ==========================================================
   // Timer 0 and 1 count enables.
   wire src0 = mf0.counter_sel ? pin0_fall : tick_t0;
   wire src1 = mf1.counter_sel ? pin1_fall : tick_t1;
   wire gate0_ok = !mf0.gate || periph_level;
   wire gate1_ok = !mf1.gate || ext1_level;
   wire en0 = timer_control_flags_reg[`BIT_T0_RUN] && gate0_ok && src0;
   wire split0 = (mode0 == MODE_SPLIT);
   wire en0h = split0 && timer_control_flags_reg[`BIT_T1_RUN] && tick_t0;
   // Timer one ignores its run bit while timer zero is split; mode 3 parks it.
   wire run1 = split0 ? 1'b1 : timer_control_flags_reg[`BIT_T1_RUN];
   wire en1 = run1 && gate1_ok && src1 && (mode1 != MODE_SPLIT);

   logic ov0, ov0h, ov1;
   always_comb begin
      tl0_next = tl0_reg;
      th0_next = th0_reg;
      ov0 = 1'b0;
      ov0h = 1'b0;
      if (en0) begin
         case (mode0)
            MODE_13BIT: begin
               {th0_next, tl0_next[4:0]} = {th0_reg, tl0_reg[4:0]} + 13'h1;
               ov0 = ({th0_reg, tl0_reg[4:0]} == 13'h1FFF);
            end
            MODE_16BIT: begin
               {th0_next, tl0_next} = {th0_reg, tl0_reg} + 16'h1;
               ov0 = ({th0_reg, tl0_reg} == 16'hFFFF);
            end
            MODE_RELOAD8: begin
               ov0 = (tl0_reg == 8'hFF);
               tl0_next = ov0 ? th0_reg : tl0_reg + 8'h1;
            end
            MODE_SPLIT: begin
               ov0 = (tl0_reg == 8'hFF);
               tl0_next = tl0_reg + 8'h1;
            end
            default: tl0_next = tl0_reg;
         endcase
      end
      if (en0h) begin
         ov0h = (th0_reg == 8'hFF);
         th0_next = th0_reg + 8'h1;
      end
   end

   always_comb begin
      tl1_next = tl1_reg;
      th1_next = th1_reg;
      ov1 = 1'b0;
      if (en1) begin
         case (mode1)
            MODE_13BIT: begin
               {th1_next, tl1_next[4:0]} = {th1_reg, tl1_reg[4:0]} + 13'h1;
               ov1 = ({th1_reg, tl1_reg[4:0]} == 13'h1FFF);
            end
            MODE_16BIT: begin
               {th1_next, tl1_next} = {th1_reg, tl1_reg} + 16'h1;
               ov1 = ({th1_reg, tl1_reg} == 16'hFFFF);
            end
            MODE_RELOAD8: begin
               ov1 = (tl1_reg == 8'hFF);
               tl1_next = ov1 ? th1_reg : tl1_reg + 8'h1;
            end
            default: tl1_next = tl1_reg;
         endcase
      end
   end

   // ==========================================================
   // Timer 2.
   wire baud_mode = timer2_control_reg[`BIT_RX_BAUD_FROM_T2] || timer2_control_reg[`BIT_TX_BAUD_FROM_T2];
   wire en2 = timer2_control_reg[`BIT_T2_RUN] && (baud_mode ? tick2 : tick_t2);
   wire ov2 = en2 && ({th2_reg, tl2_reg} == 16'hFFFF);
   wire reload2 = ov2 && (baud_mode || !timer2_control_reg[`BIT_RELOAD_DISABLE]);
   always_comb begin
      {th2_next, tl2_next} = {th2_reg, tl2_reg};
      if (reload2)
         {th2_next, tl2_next} = {rcap_hi_reg, rcap_lo_reg};
      else if (en2)
         {th2_next, tl2_next} = {th2_reg, tl2_reg} + 16'h1;
   end
   wire t2_flag_set = ov2 && !baud_mode;

   // ==========================================================
   // Flag next values; hardware set wins over a clear.
   // The timer 1 overflow flag in split mode is driven by the high byte of timer 0; overflow_pin_one still follows ov1.
   wire t1_flag_set = split0 ? ov0h : ov1;
   logic [7:0] timer_control_flags_next, timer2_control_next;
   always_comb begin
      timer_control_flags_next = timer_control_flags_reg;
      if (wr_timer_control_flags) begin
         timer_control_flags_next = reg_wdata;
         // Level-mode flags are not writable, so the write keeps the old value.
         if (!timer_control_flags_reg[`BIT_EXT1_TYPE])
            timer_control_flags_next[`BIT_EXT1_FLAG] = timer_control_flags_reg[`BIT_EXT1_FLAG];
         if (!timer_control_flags_reg[`BIT_PERIPH_TYPE])
            timer_control_flags_next[`BIT_PERIPH_FLAG] = timer_control_flags_reg[`BIT_PERIPH_FLAG];
      end
      if (vector_t0)
         timer_control_flags_next[`BIT_T0_OVERFLOW] = 1'b0;
      if (vector_t1)
         timer_control_flags_next[`BIT_T1_OVERFLOW] = 1'b0;
      if (ov0)
         timer_control_flags_next[`BIT_T0_OVERFLOW] = 1'b1;
      if (t1_flag_set)
         timer_control_flags_next[`BIT_T1_OVERFLOW] = 1'b1;
      if (timer_control_flags_reg[`BIT_EXT1_TYPE]) begin
         if (vector_ext1)
            timer_control_flags_next[`BIT_EXT1_FLAG] = 1'b0;
         if (ext1_fall)
            timer_control_flags_next[`BIT_EXT1_FLAG] = 1'b1;
      end else
         timer_control_flags_next[`BIT_EXT1_FLAG] = !ext1_level;
      if (timer_control_flags_reg[`BIT_PERIPH_TYPE]) begin
         if (vector_periph)
            timer_control_flags_next[`BIT_PERIPH_FLAG] = 1'b0;
         if (periph_fall)
            timer_control_flags_next[`BIT_PERIPH_FLAG] = 1'b1;
      end else
         timer_control_flags_next[`BIT_PERIPH_FLAG] = !periph_level;
      timer2_control_next = timer2_control_reg;
      if (wr_timer2_control)
         timer2_control_next = reg_wdata & `T2_CONTROL_MASK;
      if (t2_flag_set)
         timer2_control_next[`BIT_T2_OVERFLOW] = 1'b1;
   end

   // ==========================================================
   // Registers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timer_control_flags_reg <= `RESET_BYTE;
         timer_mode_register_reg <= `RESET_BYTE;
         timer_rate_select_reg <= `RATE_SEL_RESET;
         timer2_control_reg <= `RESET_BYTE;
         rcap_lo_reg <= `RESET_BYTE;
         rcap_hi_reg <= `RESET_BYTE;
      end else begin
         timer_control_flags_reg <= timer_control_flags_next;
         timer2_control_reg <= timer2_control_next;
         if (wr_timer_mode_register)
            timer_mode_register_reg <= reg_wdata;
         if (hit(req, `OFS_TIMER_RATE_SELECT))
            timer_rate_select_reg <= (reg_wdata & `RATE_SEL_MASK) | `RATE_SEL_RESET;
         if (hit(req, `OFS_TIMER2_RELOAD_LOW))
            rcap_lo_reg <= reg_wdata;
         if (hit(req, `OFS_TIMER2_RELOAD_HIGH))
            rcap_hi_reg <= reg_wdata;
      end
   end

   // Software writes to a count byte override the counting in that cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tl0_reg <= `RESET_BYTE;
         th0_reg <= `RESET_BYTE;
         tl1_reg <= `RESET_BYTE;
         th1_reg <= `RESET_BYTE;
         tl2_reg <= `RESET_BYTE;
         th2_reg <= `RESET_BYTE;
      end else begin
         tl0_reg <= hit(req, `OFS_T0_COUNT_LOW) ? reg_wdata : tl0_next;
         th0_reg <= hit(req, `OFS_T0_COUNT_HIGH) ? reg_wdata : th0_next;
         tl1_reg <= hit(req, `OFS_T1_COUNT_LOW) ? reg_wdata : tl1_next;
         th1_reg <= hit(req, `OFS_T1_COUNT_HIGH) ? reg_wdata : th1_next;
         tl2_reg <= hit(req, `OFS_TIMER2_COUNT_LOW) ? reg_wdata : tl2_next;
         th2_reg <= hit(req, `OFS_TIMER2_COUNT_HIGH) ? reg_wdata : th2_next;
      end
   end

   // ==========================================================
   // Outputs and read-back.
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         `OFS_TIMER_CONTROL_FLAGS: rd_mux = timer_control_flags_reg;
         `OFS_TIMER_MODE_REGISTER: rd_mux = timer_mode_register_reg;
         `OFS_T0_COUNT_LOW: rd_mux = tl0_reg;
         `OFS_T1_COUNT_LOW: rd_mux = tl1_reg;
         `OFS_T0_COUNT_HIGH: rd_mux = th0_reg;
         `OFS_T1_COUNT_HIGH: rd_mux = th1_reg;
         `OFS_TIMER_RATE_SELECT: rd_mux = timer_rate_select_reg;
         `OFS_TIMER2_CONTROL: rd_mux = timer2_control_reg;
         `OFS_TIMER2_RELOAD_LOW: rd_mux = rcap_lo_reg;
         `OFS_TIMER2_RELOAD_HIGH: rd_mux = rcap_hi_reg;
         `OFS_TIMER2_COUNT_LOW: rd_mux = tl2_reg;
         `OFS_TIMER2_COUNT_HIGH: rd_mux = th2_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   logic ovp0_reg, ovp1_reg, rxs_reg, txs_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         ovp0_reg <= 1'b0;
         ovp1_reg <= 1'b0;
         rxs_reg <= 1'b0;
         txs_reg <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         ovp0_reg <= ov0;
         ovp1_reg <= ov1;
         rxs_reg <= timer2_control_reg[`BIT_RX_BAUD_FROM_T2] ? (ov2 && baud_mode) : ov1;
         txs_reg <= timer2_control_reg[`BIT_TX_BAUD_FROM_T2] ? (ov2 && baud_mode) : ov1;
      end
   end
   assign overflow_pin_zero = ovp0_reg;
   assign overflow_pin_one = ovp1_reg;
   assign rx_shift_clk = rxs_reg;
   assign tx_shift_clk = txs_reg;
   assign t0_irq = timer_control_flags_reg[`BIT_T0_OVERFLOW];
   assign t1_irq = timer_control_flags_reg[`BIT_T1_OVERFLOW];
   assign ext1_irq = timer_control_flags_reg[`BIT_EXT1_FLAG];
   assign periph_irq = timer_control_flags_reg[`BIT_PERIPH_FLAG];
   assign t2_irq = timer2_control_reg[`BIT_T2_OVERFLOW] || timer2_control_reg[`BIT_T2_EXTERNAL];
endmodule

// >>> design/triple_timer_consts.svh
`ifndef TRIPLE_TIMER_CONSTS_SVH
`define TRIPLE_TIMER_CONSTS_SVH
// ==========================================================
// Register offsets.
`define OFS_TIMER_CONTROL_FLAGS 8'h88
`define OFS_TIMER_MODE_REGISTER 8'h89
`define OFS_T0_COUNT_LOW 8'h8A
`define OFS_T1_COUNT_LOW 8'h8B
`define OFS_T0_COUNT_HIGH 8'h8C
`define OFS_T1_COUNT_HIGH 8'h8D
`define OFS_TIMER_RATE_SELECT 8'h8E
`define OFS_TIMER2_CONTROL 8'hC8
`define OFS_TIMER2_RELOAD_LOW 8'hCA
`define OFS_TIMER2_RELOAD_HIGH 8'hCB
`define OFS_TIMER2_COUNT_LOW 8'hCC
`define OFS_TIMER2_COUNT_HIGH 8'hCD
// ==========================================================
// Field positions.
`define BIT_T1_OVERFLOW 7
`define BIT_T1_RUN 6
`define BIT_T0_OVERFLOW 5
`define BIT_T0_RUN 4
`define BIT_EXT1_FLAG 3
`define BIT_EXT1_TYPE 2
`define BIT_PERIPH_FLAG 1
`define BIT_PERIPH_TYPE 0
`define BIT_RATE_SEL_TWO 5
`define BIT_RATE_SEL_ONE 4
`define BIT_RATE_SEL_ZERO 3
`define BIT_T2_OVERFLOW 7
`define BIT_T2_EXTERNAL 6
`define BIT_RX_BAUD_FROM_T2 5
`define BIT_TX_BAUD_FROM_T2 4
`define BIT_T2_RUN 2
`define BIT_RELOAD_DISABLE 0
// ==========================================================
// Reset values and timing.
`define RESET_BYTE 8'h00
`define RATE_SEL_RESET 8'h01
`define RATE_SEL_MASK 8'h38
`define T2_CONTROL_MASK 8'hF5
`define SLOW_DIV 4'd12
`define FAST_DIV 4'd4
`define BAUD_DIV 4'd2
`endif

// >>> design/triple_timer_pkg.sv
package triple_timer_pkg;
   typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} timer_mode_t;
   typedef struct packed {
      logic gate;
      logic counter_sel;
      logic mode_bit_high;
      logic mode_bit_low;
   } mode_field_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

// >>> test/core_vector_model.sv
`timescale 1ns/1ps
// ==========================================================
// Processor side: acknowledges flags by vectoring.
module core_vector_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] flags,
   input wire logic [3:0] enable,
   input wire logic slow,
   output logic [3:0] vector
);
   logic [3:0] seen_reg;
   // A vector is never repeated in the next cycle, so one request gets one acknowledge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seen_reg <= 4'h0;
         vector <= 4'h0;
      end else begin
         seen_reg <= flags & enable;
         vector <= flags & enable & ~vector & (slow ? seen_reg : 4'hF);
      end
   end
endmodule

// >>> test/triple_timer_counter_props.sv
`timescale 1ns/1ps
// ==========================================================
// Checks on overflow pins, shift clocks and flags.
module timer_port_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic ext_irq_one_n,
   input wire logic periph_irq_n,
   input wire logic vector_t0,
   input wire logic overflow_pin_zero,
   input wire logic overflow_pin_one,
   input wire logic t0_irq,
   input wire logic ext1_irq,
   input wire logic periph_irq,
   input wire logic rx_shift_clk,
   input wire logic tx_shift_clk
);
   logic [3:0] ext_age;
   logic [3:0] per_age;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Ages saturate, so a long quiet spell never wraps into a false recent low.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_age <= 4'hF;
         per_age <= 4'hF;
      end else begin
         ext_age <= ext_irq_one_n ? ext_age + {3'h0, ext_age != 4'hF} : 4'h0;
         per_age <= periph_irq_n ? per_age + {3'h0, per_age != 4'hF} : 4'h0;
      end
   end
   sequence t0_wrap;
      $rose(overflow_pin_zero);
   endsequence
   sequence t0_ack;
      vector_t0 && !overflow_pin_zero;
   endsequence
   pin0_gap_a: assert property (overflow_pin_zero |=> !overflow_pin_zero [*3])
      else $error("timer zero overflow pulses too close");
   pin1_gap_a: assert property (overflow_pin_one |=> !overflow_pin_one [*3])
      else $error("timer one overflow pulses too close");
   t0_flag_a: assert property (t0_wrap |-> ##[0:1] t0_irq)
      else $error("timer zero flag not set on overflow");
   t0_vector_a: assert property (t0_ack |=> !t0_irq || overflow_pin_zero)
      else $error("timer zero flag not cleared by vector");
   tx_pulse_a: assert property (tx_shift_clk |=> !tx_shift_clk)
      else $error("transmit shift clock longer than one cycle");
   rx_pulse_a: assert property (rx_shift_clk |=> !rx_shift_clk)
      else $error("receive shift clock longer than one cycle");
   ext1_cause_a: assert property ($rose(ext1_irq) |-> ext_age < 4'h8)
      else $error("interrupt one flag rose without a low pin");
   periph_cause_a: assert property ($rose(periph_irq) |-> per_age < 4'h8)
      else $error("peripheral flag rose without a low input");
endmodule
bind triple_timer_counter timer_port_checker timer_port_checker_i (.clk(clk), .reset(reset),
   .ext_irq_one_n(ext_irq_one_n), .periph_irq_n(periph_irq_n), .vector_t0(vector_t0),
   .overflow_pin_zero(overflow_pin_zero), .overflow_pin_one(overflow_pin_one), .t0_irq(t0_irq),
   .ext1_irq(ext1_irq), .periph_irq(periph_irq), .rx_shift_clk(rx_shift_clk), .tx_shift_clk(tx_shift_clk));

// >>> test/triple_timer_counter_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
// ==========================================================
// Bench: register reads are checked in order by a watcher.
module triple_timer_counter_test;
   logic clk, reset, reg_wr, reg_rd, count_pin_one, ext_irq_one_n, periph_irq_n, slow, rd_seen;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, e, bf, bt;
   logic [3:0] vec, vec_en;
   logic overflow_pin_zero, overflow_pin_one, t0_irq, t1_irq, ext1_irq, periph_irq, t2_irq;
   logic rx_shift_clk, tx_shift_clk;
   logic [7:0] exp_q[$];
   logic [7:0] regs[13] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8F};
   int n_errors = 0, n_compared = 0, n, c1, c2, th, p1_cnt = 0, tx_cnt = 0;
   wire [5:0] mon = {t2_irq, rx_shift_clk, tx_shift_clk, t1_irq, overflow_pin_one, overflow_pin_zero};
   triple_timer_counter triple_timer_counter_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin_zero(1'b1), .count_pin_one(count_pin_one),
      .ext_irq_one_n(ext_irq_one_n), .periph_irq_n(periph_irq_n), .vector_t0(vec[0]), .vector_t1(vec[1]),
      .vector_ext1(vec[2]), .vector_periph(vec[3]), .overflow_pin_zero(overflow_pin_zero),
      .overflow_pin_one(overflow_pin_one), .t0_irq(t0_irq), .t1_irq(t1_irq), .ext1_irq(ext1_irq),
      .periph_irq(periph_irq), .t2_irq(t2_irq), .rx_shift_clk(rx_shift_clk), .tx_shift_clk(tx_shift_clk));
   core_vector_model core_vector_model_i (.clk(clk), .reset(reset), .flags({periph_irq, ext1_irq, t1_irq, t0_irq}),
      .enable(vec_en), .slow(slow), .vector(vec));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      p1_cnt += overflow_pin_one;
      tx_cnt += tx_shift_clk;
      if (rd_seen) begin
         e = exp_q.pop_front();
         `CHK(reg_rdata, e)
      end
      rd_seen <= reg_rd;
   end
   task automatic end_sim();
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic t0cfg(input logic [7:0] m, input logic [7:0] tl, input logic [7:0] thv);
      wr(8'h89, m);
      wr(8'h8A, tl);
      wr(8'h8C, thv);
   endtask
   // Waits for a monitored output to be high, giving up after lim cycles.
   task automatic waith(input int k, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (mon[k] !== 1'b1 && cnt < lim);
   endtask
   task automatic pin(input int s, input logic v);
      @(posedge clk);
      if (s == 1) ext_irq_one_n <= v;
      else if (s == 0) periph_irq_n <= v;
      else count_pin_one <= v;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
   initial begin
      {reg_wr, reg_rd, slow, rd_seen} = 4'h0;
      {count_pin_one, ext_irq_one_n, periph_irq_n} = 3'h7;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      vec_en = 4'h0;
      reset = 1'b1;
      void'($urandom(32'hC82B));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      foreach (regs[i]) rd(regs[i], (regs[i] == 8'h8E) ? 8'h01 : 8'h00);
      wr(8'h8E, 8'hFF);
      rd(8'h8E, 8'h39);
      wr(8'hC8, 8'h0A);
      rd(8'hC8, 8'h00);
      t0cfg(8'h00, 8'h1C, 8'hFF);
      wr(8'h88, 8'h10);
      waith(0, 40, n);
      `CHK(n inside {[8:22]}, 1'b1)
      rd(8'h88, 8'h30);
      wr(8'h88, 8'h00);
      t0cfg(8'h01, 8'h1C, 8'hFF);
      vec_en <= 4'h1;
      slow <= 1'b1;
      wr(8'h88, 8'h10);
      waith(0, 100, c1);
      waith(0, 1000, c2);
      `CHK({c1 == 100, (c1 + c2) inside {[890:930]}}, 2'b11)
      repeat (6) @(posedge clk);
      rd(8'h88, 8'h10);
      vec_en <= 4'h0;
      wr(8'h88, 8'h00);
      for (int r = 0; r < 2; r++) begin
         th = 248 + $urandom % 8;
         wr(8'h8E, r ? 8'h08 : 8'h00);
         t0cfg(8'h02, 8'(th), 8'(th));
         wr(8'h88, 8'h10);
         waith(0, 400, n);
         waith(0, 400, n);
         `CHK(n, (256 - th) * (r ? 4 : 12))
         wr(8'h88, 8'h00);
      end
      t0cfg(8'h0A, 8'hFF, 8'hFF);
      periph_irq_n <= 1'b0;
      wr(8'h88, 8'h10);
      waith(0, 50, n);
      `CHK(n, 50)
      periph_irq_n <= 1'b1;
      waith(0, 50, n);
      `CHK(n < 20, 1'b1)
      wr(8'h88, 8'h00);
      wr(8'h8B, 8'h5A);
      t0cfg(8'h33, 8'hFF, 8'hFE);
      wr(8'h88, 8'h40);
      waith(2, 50, n);
      `CHK(n < 50, 1'b1)
      rd(8'h88, 8'hC0);
      rd(8'h8B, 8'h5A);
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h60);
      wr(8'h8B, 8'hFF);
      wr(8'h8D, 8'hFD);
      wr(8'h88, 8'h40);
      c1 = p1_cnt;
      c2 = tx_cnt;
      repeat (4) pin(2, 1'b1);
      `CHK(p1_cnt - c1, 0)
      pin(2, 1'b0);
      pin(2, 1'b1);
      `CHK(p1_cnt - c1, 1)
      `CHK(tx_cnt - c2, 1)
      wr(8'h88, 8'h00);
      for (int s = 0; s < 2; s++) begin
         bf = s ? 8'h08 : 8'h02;
         bt = s ? 8'h04 : 8'h01;
         wr(8'h88, bt);
         pin(s, 1'b0);
         pin(s, 1'b1);
         rd(8'h88, bt | bf);
         wr(8'h88, bt);
         rd(8'h88, bt);
         vec_en <= s ? 4'h4 : 4'h8;
         pin(s, 1'b0);
         pin(s, 1'b1);
         rd(8'h88, bt);
         vec_en <= 4'h0;
         wr(8'h88, 8'h00);
         pin(s, 1'b0);
         wr(8'h88, 8'h00);
         rd(8'h88, bf);
         pin(s, 1'b1);
         rd(8'h88, 8'h00);
      end
      wr(8'h8E, 8'h00);
      foreach (regs[i]) if (i > 7 && i < 12) wr(regs[i], i[0] ? 8'hFF : 8'hFC);
      wr(8'hC8, 8'h34);
      waith(3, 50, n);
      waith(3, 50, n);
      `CHK(n, 8)
      waith(4, 50, n);
      waith(4, 50, n);
      `CHK(n, 8)
      rd(8'hC8, 8'h34);
      wr(8'hC8, 8'h00);
      wr(8'h8E, 8'h20);
      wr(8'hC8, 8'h04);
      waith(5, 50, n);
      `CHK(n inside {[1:22]}, 1'b1)
      rd(8'hCD, 8'hFF);
      wr(8'hC8, 8'h00);
      @(posedge clk);
      `CHK(t2_irq, 1'b0)
      wr(8'hC8, 8'h40);
      repeat (2) @(posedge clk);
      `CHK(t2_irq, 1'b1)
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
